// ### tb/core_bus_model.sv
`timescale 1ns/1ns
module core_bus_model (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic slow, // Answer late
  input wire logic core_irq_valid, // Offer
  input wire irq_router_pkg::core_req_t core_req, // Offer data
  output logic core_ack, // Take offer
  input wire logic bus_msg_valid, // Bus message
  input wire irq_router_pkg::irq_msg_t bus_msg, // Bus data
  output logic bus_msg_ready, // Take message
  output irq_router_pkg::core_req_t got_req, // Last offer taken
  output irq_router_pkg::irq_msg_t got_msg, // Last message taken
  output int n_req, // Offers taken
  output int n_msg // Messages taken
);
  int wc;
  int wb;
  // Answers off the sampling edge; bus messages after a wait, core offers at once unless slow
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      bus_msg_ready <= 1'b0;
      wc <= 0;
      wb <= 0;
    end else begin
      core_ack <= core_irq_valid && !core_ack && wc >= (slow ? 6 : 0);
      wc <= (core_irq_valid && !core_ack) ? wc + 1 : 0;
      bus_msg_ready <= bus_msg_valid && !bus_msg_ready && wb >= (slow ? 6 : 1);
      wb <= (bus_msg_valid && !bus_msg_ready) ? wb + 1 : 0;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n_req <= 0;
      n_msg <= 0;
    end else begin
      if (core_irq_valid && core_ack) begin
        got_req <= core_req;
        n_req <= n_req + 1;
      end
      if (bus_msg_valid && bus_msg_ready) begin
        got_msg <= bus_msg;
        n_msg <= n_msg + 1;
      end
    end
  end
endmodule // core_bus_model

// ### tb/irq_router_asserts.sv
`timescale 1ns/1ns
module irq_router_asserts (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic acc_valid, // Access
  input wire irq_router_pkg::acc_req_t acc_req, // Request
  input wire logic acc_ack, // Answer
  input wire logic acc_hit, // Hit
  input wire logic [31:0] acc_rdata, // Read data
  input wire logic core_irq_valid, // Offer
  input wire irq_router_pkg::core_req_t core_req, // Offer data
  input wire logic core_ack, // Core take
  input wire logic in_msg_valid, // Inbound
  input wire logic in_msg_ready, // Inbound free
  input wire logic bus_msg_valid, // Outbound
  input wire irq_router_pkg::irq_msg_t bus_msg, // Outbound data
  input wire logic bus_msg_ready // Bus take
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_inside;
    acc_req.addr[31:12] == irq_router_pkg::BASE_RST[31:12];
  endsequence
  sequence s_core_take;
    core_irq_valid && core_ack;
  endsequence
  chk_ack_follow:
    assert property (acc_valid |=> acc_ack) else $error("access not answered");
  chk_ack_cause:
    assert property (acc_ack |-> $past(acc_valid)) else $error("answer without access");
  chk_hit_inside:
    assert property (acc_valid ##0 s_inside |=> acc_hit) else $error("region access not hit");
  chk_hit_outside:
    assert property (acc_valid && acc_req.addr[31:12] != irq_router_pkg::BASE_RST[31:12] |=> !acc_hit)
      else $error("outside access hit");
  chk_write_zero:
    assert property (acc_valid && acc_req.write |=> acc_rdata == 32'h0) else $error("write returned data");
  chk_offer_hold:
    assert property (core_irq_valid && !core_ack |=> core_irq_valid && $stable(core_req))
      else $error("offer not held");
  chk_offer_drop:
    assert property (s_core_take |=> !core_irq_valid) else $error("offer kept after take");
  chk_nmi_vec:
    assert property (core_irq_valid && core_req.nmi |-> core_req.vector == irq_router_pkg::NMI_VECTOR)
      else $error("nmi with wrong vector");
  chk_bus_hold:
    assert property (bus_msg_valid && !bus_msg_ready |=> bus_msg_valid && $stable(bus_msg))
      else $error("bus message not held");
  chk_in_take:
    assert property ($fell(in_msg_ready) |-> $past(in_msg_valid)) else $error("slot filled without message");
endmodule // irq_router_asserts

bind local_interrupt_source_router irq_router_asserts chk_i (.clk(clk), .rst_b(rst_b),
  .acc_valid(acc_valid), .acc_req(acc_req), .acc_ack(acc_ack), .acc_hit(acc_hit), .acc_rdata(acc_rdata),
  .core_irq_valid(core_irq_valid), .core_req(core_req), .core_ack(core_ack), .in_msg_valid(in_msg_valid),
  .in_msg_ready(in_msg_ready), .bus_msg_valid(bus_msg_valid), .bus_msg(bus_msg), .bus_msg_ready(bus_msg_ready));

// ### tb/local_interrupt_source_router_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module local_interrupt_source_router_tb;
  logic clk = 1'b0, rst_b = 1'b0, pin_a = 1'b0, pin_b = 1'b0, legacy = 1'b0, perf = 1'b0, therm = 1'b0;
  logic acc_valid = 1'b0, in_msg_valid = 1'b0, slow = 1'b0;
  logic acc_ack, acc_hit, core_irq_valid, core_ack, core_legacy_intr, in_msg_ready, bus_msg_valid, bus_msg_ready;
  logic [31:0] acc_rdata, rd;
  irq_router_pkg::acc_req_t acc_req = '0;
  irq_router_pkg::irq_msg_t in_msg = '0, bus_msg, got_msg;
  irq_router_pkg::core_req_t core_req, got_req;
  int n_req, n_msg, n0, n_errors = 0, n_tests = 0, cyc = 0;
  always #4 clk = ~clk;
  local_interrupt_source_router dut (.clk(clk), .rst_b(rst_b), .local_irq_pin_a(pin_a), .local_irq_pin_b(pin_b),
    .legacy_intr(legacy), .perf_overflow(perf), .thermal_trip(therm), .acc_valid(acc_valid), .acc_req(acc_req),
    .acc_ack(acc_ack), .acc_hit(acc_hit), .acc_rdata(acc_rdata), .core_irq_valid(core_irq_valid),
    .core_req(core_req), .core_ack(core_ack), .core_legacy_intr(core_legacy_intr), .in_msg_valid(in_msg_valid),
    .in_msg(in_msg), .in_msg_ready(in_msg_ready), .bus_msg_valid(bus_msg_valid), .bus_msg(bus_msg),
    .bus_msg_ready(bus_msg_ready));
  core_bus_model peer (.clk(clk), .rst_b(rst_b), .slow(slow), .core_irq_valid(core_irq_valid),
    .core_req(core_req), .core_ack(core_ack), .bus_msg_valid(bus_msg_valid), .bus_msg(bus_msg),
    .bus_msg_ready(bus_msg_ready), .got_req(got_req), .got_msg(got_msg), .n_req(n_req), .n_msg(n_msg));
  task automatic acc(input logic wr, input logic [11:0] off, input logic [31:0] wd, input logic lk = 1'b0,
      input logic out = 1'b0);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_req = '{write: wr, lock: lk, addr: {out ? 20'h00001 : irq_router_pkg::BASE_RST[31:12], off}, wdata: wd};
    @(negedge clk);
    acc_valid = 1'b0;
    rd = acc_rdata;
    `CHK("acc_hit", !out, acc_hit)
  endtask
  task automatic wait_req(input int n, input logic [7:0] v, input logic nmi);
    repeat (300) if (n_req == n) @(negedge clk);
    `CHK("vector", v, got_req.vector)
    `CHK("nmi", nmi, got_req.nmi)
  endtask
  task automatic wait_msg(input int n);
    repeat (300) if (n_msg == n) @(negedge clk);
  endtask
  task automatic t_reset();
    acc(1'b0, irq_router_pkg::OFF_TBL_FIRST, 32'h0);
    `CHK("mask_rst", 1'b1, rd[16])
    legacy = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("legacy_on", 1'b1, core_legacy_intr)
    acc(1'b1, irq_router_pkg::OFF_SVR, 32'h0000_0100, 1'b0, 1'b1);
    acc(1'b1, irq_router_pkg::OFF_SVR, 32'h0000_0100, 1'b1);
    acc(1'b0, irq_router_pkg::OFF_SVR, 32'h0);
    `CHK("enable", 1'b1, rd[8])
    repeat (3) @(negedge clk);
    `CHK("legacy_off", 1'b0, core_legacy_intr)
    legacy = 1'b0;
  endtask
  task automatic t_local();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      if (i == 2) continue;
      v = 8'h30 + 8'(i);
      acc(1'b1, irq_router_pkg::OFF_TBL_FIRST + 12'(16 * i), (i == 1) ? 32'h0000_0100 : 32'(v));
      n0 = n_req;
      @(negedge clk);
      case (i)
        0: pin_a = 1'b1;
        1: pin_b = 1'b1;
        3: perf = 1'b1;
        default: therm = 1'b1;
      endcase
      repeat (4) @(negedge clk);
      {pin_a, pin_b, perf, therm} = 4'h0;
      wait_req(n0, (i == 1) ? irq_router_pkg::NMI_VECTOR : v, i == 1);
    end
  endtask
  task automatic t_prio();
    slow = 1'b1;
    n0 = n_req;
    @(negedge clk);
    {perf, therm} = 2'h3;
    @(negedge clk);
    {perf, therm} = 2'h0;
    wait_req(n0, 8'h33, 1'b0);
    wait_req(n0 + 1, 8'h34, 1'b0);
    slow = 1'b0;
  endtask
  task automatic t_timer_err();
    acc(1'b1, irq_router_pkg::OFF_TBL_FIRST + 12'h020, 32'h0000_0044);
    acc(1'b1, irq_router_pkg::OFF_TBL_FIRST + 12'h050, 32'h0000_0055);
    n0 = n_req;
    acc(1'b1, irq_router_pkg::OFF_TMR_INIT, 32'h0000_0005);
    wait_req(n0, 8'h44, 1'b0);
    acc(1'b0, irq_router_pkg::OFF_TMR_CUR, 32'h0);
    `CHK("timer_cur", 32'h0, rd)
    acc(1'b0, 12'h040, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wait_req(n0 + 1, 8'h55, 1'b0);
    acc(1'b0, irq_router_pkg::OFF_ERR, 32'h0);
    `CHK("err_bit", 1'b1, rd[0])
  endtask
  task automatic t_proc_msg();
    acc(1'b1, irq_router_pkg::OFF_ICR_HI, 32'h0500_0000);
    n0 = n_msg;
    acc(1'b1, irq_router_pkg::OFF_ICR_LO, 32'h0000_0077);
    wait_msg(n0);
    `CHK("dest", 8'h05, got_msg.dest)
    `CHK("msg_vec", 8'h77, got_msg.vector)
    n0 = n_req;
    acc(1'b1, irq_router_pkg::OFF_ICR_LO, 32'h0004_0078);
    wait_req(n0, 8'h78, 1'b0);
    `CHK("no_bus", 1, n_msg)
    n0 = n_msg;
    acc(1'b1, irq_router_pkg::OFF_ICR_LO, 32'h000C_0079);
    wait_msg(n0);
    `CHK("bcast", 1'b1, got_msg.broadcast)
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] v);
    @(negedge clk);
    in_msg = '{dest: d, group: 1'b0, broadcast: 1'b0, level: 1'b1, mode: irq_router_pkg::DLV_FIXED, vector: v};
    in_msg_valid = 1'b1;
    while (in_msg_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    in_msg_valid = 1'b0;
  endtask
  task automatic t_inbound();
    n0 = n_req;
    send(8'h09, 8'h90);
    send(irq_router_pkg::ID_RST, 8'h88);
    wait_req(n0, 8'h88, 1'b0);
    `CHK("level", 1'b1, got_req.level)
    repeat (20) @(negedge clk);
    `CHK("n_req", n0 + 1, n_req)
  endtask
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_local();
    t_prio();
    t_timer_err();
    t_proc_msg();
    t_inbound();
    end_of_test();
  end
endmodule // local_interrupt_source_router_tb

// ### verilog/irq_count_timer.sv
`timescale 1ns/1ns
module irq_count_timer (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset
  input wire logic load, // Load pulse
  input wire logic [31:0] load_value, // Start count, zero stops
  input wire logic periodic, // Reload on expiry
  output logic [31:0] count, // Current count
  output logic fire // One-cycle expiry pulse
);

  logic [31:0] count_r, count_nxt;
  logic fire_r, fire_nxt;
  logic [31:0] reload_r, reload_nxt;

  always_comb begin
    count_nxt = count_r;
    reload_nxt = reload_r;
    fire_nxt = 1'b0;
    if (load) begin
      count_nxt = load_value;
      reload_nxt = load_value;
    end else if (count_r != 32'h00000000) begin
      count_nxt = count_r - 32'h00000001;
      if (count_r == 32'h00000001) begin
        fire_nxt = 1'b1;
        if (periodic) begin
          count_nxt = reload_r;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 32'h00000000;
      reload_r <= 32'h00000000;
      fire_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      reload_r <= reload_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign count = count_r;
  assign fire = fire_r;

endmodule // irq_count_timer

// ### verilog/irq_router_pkg.sv
package irq_router_pkg;

  localparam int NUM_LOCAL = 6;
  localparam int NUM_SRC = 8;

  localparam int SRC_PIN_A = 0;
  localparam int SRC_PIN_B = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_PERF = 3;
  localparam int SRC_THERM = 4;
  localparam int SRC_ERR = 5;
  localparam int SRC_MSG = 6;
  localparam int SRC_SELF = 7;

  localparam logic [31:0] BASE_RST = 32'hFEE00000;

  localparam logic [11:0] OFF_ID = 12'h020;
  localparam logic [11:0] OFF_GROUP = 12'h0D0;
  localparam logic [11:0] OFF_SVR = 12'h0F0;
  localparam logic [11:0] OFF_ERR = 12'h280;
  localparam logic [11:0] OFF_ICR_LO = 12'h300;
  localparam logic [11:0] OFF_ICR_HI = 12'h310;
  localparam logic [11:0] OFF_TBL_FIRST = 12'h400;
  localparam logic [11:0] OFF_TBL_END = 12'h460;
  localparam logic [11:0] OFF_TMR_INIT = 12'h480;
  localparam logic [11:0] OFF_TMR_CUR = 12'h490;

  localparam int VEC_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int DESTMODE_BIT = 11;
  localparam int DSTAT_BIT = 12;
  localparam int LEVEL_BIT = 15;
  localparam int MASK_BIT = 16;
  localparam int PERIODIC_BIT = 17;
  localparam int SHORT_LSB = 18;
  localparam int DEST_LSB = 24;
  localparam int ENABLE_BIT = 8;

  localparam int ERR_UNMAPPED = 0;
  localparam int ERR_ALIGN = 1;
  localparam int ERR_BUSY = 2;
  localparam int NUM_ERR = 3;

  localparam logic [7:0] NMI_VECTOR = 8'h02;
  localparam logic [7:0] ID_RST = 8'h00;
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] BCAST_DEST = 8'hFF;
  localparam logic ENABLE_RST = 1'b0;

  typedef enum logic [1:0] {DLV_FIXED, DLV_NMI, DLV_EXTINT, DLV_RSVD} dlv_mode_t;
  typedef enum logic [1:0] {SH_NONE, SH_SELF, SH_ALL, SH_OTHERS} shorthand_t;

  typedef struct packed {
    logic mask;
    logic level;
    dlv_mode_t mode;
    logic [7:0] vector;
  } route_entry_t;

  localparam route_entry_t ENTRY_RST = '{mask: 1'b1, level: 1'b0, mode: DLV_FIXED, vector: 8'h00};

  typedef struct packed {
    logic [7:0] dest;
    logic group;
    logic broadcast;
    logic level;
    dlv_mode_t mode;
    logic [7:0] vector;
  } irq_msg_t;

  typedef struct packed {
    logic [7:0] vector;
    logic level;
    logic nmi;
    logic extint;
  } core_req_t;

  typedef struct packed {
    logic write;
    logic lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } acc_req_t;

endpackage

// ### verilog/local_interrupt_source_router.sv
`timescale 1ns/1ns
// Contract
// - Both local pins accept edge or level requests from attached devices.
// - Accept forwarded interrupt messages from the external I/O router.
// - Send processor interrupts to one processor, a group, or self.
// - Internal timer raises a local interrupt when its count is reached.
// - Performance counter overflow raises a local interrupt.
// - Thermal trip raises a local interrupt.
// - Detect internal errors like unmapped access; optionally interrupt on them.
// - Each local source has its own table entry setting delivery.
// - Pin b entry in NMI mode delivers vector 2.
// - Router and processor messages go through message logic, not table.
// - Writing the command register issues a message onto the system bus, except with the self shorthand, which is only delivered locally.
// - Received messages delivered automatically using their vector and trigger mode.
// - When disabled, the core takes interrupts from the legacy controller.
// - Registers are memory mapped, readable and writable by moves.
// - 4-KByte region at FEE00000H handled internally, no external cycles.
// - Lock prefix on register access is ignored.
module local_interrupt_source_router (
  input wire logic clk, // Processor clock
  input wire logic rst_b, // Core reset
  input wire logic local_irq_pin_a, // Local interrupt pin a
  input wire logic local_irq_pin_b, // Local interrupt pin b
  input wire logic legacy_intr, // Legacy controller request pin
  input wire logic perf_overflow, // Counter overflow event
  input wire logic thermal_trip, // Thermal sensor trip
  input wire logic acc_valid, // Core memory access pulse
  input wire irq_router_pkg::acc_req_t acc_req, // Access request
  output logic acc_ack, // Access answered
  output logic acc_hit, // Handled internally
  output logic [31:0] acc_rdata, // Read data
  output logic core_irq_valid, // Interrupt offered to core
  output irq_router_pkg::core_req_t core_req, // Offered interrupt
  input wire logic core_ack, // Core takes offer
  output logic core_legacy_intr, // Legacy passthrough
  input wire logic in_msg_valid, // Inbound message valid
  input wire irq_router_pkg::irq_msg_t in_msg, // Inbound message
  output logic in_msg_ready, // Inbound slot free
  output logic bus_msg_valid, // Outbound message valid
  output irq_router_pkg::irq_msg_t bus_msg, // Outbound message
  input wire logic bus_msg_ready // Bus takes message
);

  typedef enum logic {DS_IDLE, DS_OFFER} dlv_state_t;

  logic [2:0] pins_sync;
  logic [31:0] tmr_count;
  logic tmr_fire;
  logic tmr_load;

  irq_router_pkg::route_entry_t entry_r [irq_router_pkg::NUM_LOCAL];
  irq_router_pkg::route_entry_t entry_nxt [irq_router_pkg::NUM_LOCAL];
  logic periodic_r, periodic_nxt;
  logic [7:0] id_r, id_nxt;
  logic [7:0] group_r, group_nxt;
  logic enable_r, enable_nxt;
  logic [31:0] icr_lo_r, icr_lo_nxt;
  logic [7:0] icr_dest_r, icr_dest_nxt;
  logic [irq_router_pkg::NUM_ERR-1:0] err_r, err_nxt;
  logic err_evt_r, err_evt_nxt;
  logic acc_ack_r, acc_ack_nxt;
  logic acc_hit_r, acc_hit_nxt;
  logic [31:0] acc_rdata_r, acc_rdata_nxt;

  logic [11:0] off;
  logic in_region;
  logic hit;
  logic aligned;
  logic in_tbl;
  logic [2:0] tbl_idx;
  logic icr_send;
  irq_router_pkg::shorthand_t send_sh;
  logic busy;
  irq_router_pkg::irq_msg_t in_slot_r, in_slot_nxt;
  irq_router_pkg::irq_msg_t self_slot_r, self_slot_nxt;
  irq_router_pkg::irq_msg_t bus_msg_r, bus_msg_nxt;
  logic bus_msg_valid_r, bus_msg_valid_nxt;
  logic in_ready_r, in_ready_nxt;
  logic in_match;
  logic msg_set;
  logic self_set;
  irq_router_pkg::irq_msg_t send_msg;
  logic [irq_router_pkg::NUM_SRC-1:0] pend_r, pend_nxt;
  logic [irq_router_pkg::NUM_LOCAL-1:0] raw;
  logic [irq_router_pkg::NUM_LOCAL-1:0] prev_r, prev_nxt;
  logic [irq_router_pkg::NUM_LOCAL-1:0] set_loc;
  dlv_state_t dlv_r, dlv_nxt;
  logic [2:0] grant_r, grant_nxt;
  logic core_valid_r, core_valid_nxt;
  irq_router_pkg::core_req_t core_req_r, core_req_nxt;
  logic legacy_r, legacy_nxt;
  irq_router_pkg::irq_msg_t pick;

  always_comb begin
    off = acc_req.addr[11:0];
    in_region = acc_req.addr[31:12] == irq_router_pkg::BASE_RST[31:12];
    hit = acc_valid && in_region;
    aligned = off[3:0] == 4'h0;
    in_tbl = off >= irq_router_pkg::OFF_TBL_FIRST && off < irq_router_pkg::OFF_TBL_END;
    tbl_idx = 3'(off[11:4] - irq_router_pkg::OFF_TBL_FIRST[11:4]);
    send_sh = irq_router_pkg::shorthand_t'(acc_req.wdata[irq_router_pkg::SHORT_LSB +: 2]);
    busy = bus_msg_valid_r || pend_r[irq_router_pkg::SRC_SELF];
    icr_send = 1'b0;
    tmr_load = 1'b0;
    for (int i = 0; i < irq_router_pkg::NUM_LOCAL; i++) begin
      entry_nxt[i] = entry_r[i];
    end
    periodic_nxt = periodic_r;
    id_nxt = id_r;
    group_nxt = group_r;
    enable_nxt = enable_r;
    icr_lo_nxt = icr_lo_r;
    icr_dest_nxt = icr_dest_r;
    err_nxt = err_r;
    err_evt_nxt = 1'b0;
    acc_ack_nxt = acc_valid;
    acc_hit_nxt = hit;
    acc_rdata_nxt = 32'h00000000;
    // Lock attribute is not looked at: no locked cycle happens
    if (hit && !aligned) begin
      err_nxt[irq_router_pkg::ERR_ALIGN] = 1'b1;
    end else if (hit && acc_req.write) begin
      if (off == irq_router_pkg::OFF_ID) begin
        id_nxt = acc_req.wdata[irq_router_pkg::DEST_LSB +: 8];
      end else if (off == irq_router_pkg::OFF_GROUP) begin
        group_nxt = acc_req.wdata[irq_router_pkg::DEST_LSB +: 8];
      end else if (off == irq_router_pkg::OFF_SVR) begin
        enable_nxt = acc_req.wdata[irq_router_pkg::ENABLE_BIT];
      end else if (off == irq_router_pkg::OFF_ERR) begin
        err_nxt = '0;
      end else if (off == irq_router_pkg::OFF_ICR_LO) begin
        if (busy) begin
          err_nxt[irq_router_pkg::ERR_BUSY] = 1'b1;
        end else begin
          icr_lo_nxt = acc_req.wdata;
          icr_send = 1'b1;
        end
      end else if (off == irq_router_pkg::OFF_ICR_HI) begin
        icr_dest_nxt = acc_req.wdata[irq_router_pkg::DEST_LSB +: 8];
      end else if (in_tbl) begin
        entry_nxt[tbl_idx] = '{mask: acc_req.wdata[irq_router_pkg::MASK_BIT],
                               level: acc_req.wdata[irq_router_pkg::LEVEL_BIT],
                               mode: irq_router_pkg::dlv_mode_t'(acc_req.wdata[irq_router_pkg::MODE_LSB +: 2]),
                               vector: acc_req.wdata[irq_router_pkg::VEC_LSB +: 8]};
        if (tbl_idx == 3'(irq_router_pkg::SRC_TIMER)) begin
          periodic_nxt = acc_req.wdata[irq_router_pkg::PERIODIC_BIT];
        end
      end else if (off == irq_router_pkg::OFF_TMR_INIT) begin
        tmr_load = 1'b1;
      end else if (off != irq_router_pkg::OFF_TMR_CUR) begin
        err_nxt[irq_router_pkg::ERR_UNMAPPED] = 1'b1;
      end
    end else if (hit) begin
      if (off == irq_router_pkg::OFF_ID) begin
        acc_rdata_nxt[irq_router_pkg::DEST_LSB +: 8] = id_r;
      end else if (off == irq_router_pkg::OFF_GROUP) begin
        acc_rdata_nxt[irq_router_pkg::DEST_LSB +: 8] = group_r;
      end else if (off == irq_router_pkg::OFF_SVR) begin
        acc_rdata_nxt[irq_router_pkg::ENABLE_BIT] = enable_r;
      end else if (off == irq_router_pkg::OFF_ERR) begin
        acc_rdata_nxt[irq_router_pkg::NUM_ERR-1:0] = err_r;
      end else if (off == irq_router_pkg::OFF_ICR_LO) begin
        acc_rdata_nxt = icr_lo_r;
        acc_rdata_nxt[irq_router_pkg::DSTAT_BIT] = busy;
      end else if (off == irq_router_pkg::OFF_ICR_HI) begin
        acc_rdata_nxt[irq_router_pkg::DEST_LSB +: 8] = icr_dest_r;
      end else if (in_tbl) begin
        acc_rdata_nxt[irq_router_pkg::VEC_LSB +: 8] = entry_r[tbl_idx].vector;
        acc_rdata_nxt[irq_router_pkg::MODE_LSB +: 2] = entry_r[tbl_idx].mode;
        acc_rdata_nxt[irq_router_pkg::DSTAT_BIT] = pend_r[tbl_idx];
        acc_rdata_nxt[irq_router_pkg::LEVEL_BIT] = entry_r[tbl_idx].level;
        acc_rdata_nxt[irq_router_pkg::MASK_BIT] = entry_r[tbl_idx].mask;
        acc_rdata_nxt[irq_router_pkg::PERIODIC_BIT] = (tbl_idx == 3'(irq_router_pkg::SRC_TIMER)) && periodic_r;
      end else if (off == irq_router_pkg::OFF_TMR_INIT) begin
        acc_rdata_nxt = 32'h00000000;
      end else if (off == irq_router_pkg::OFF_TMR_CUR) begin
        acc_rdata_nxt = tmr_count;
      end else begin
        err_nxt[irq_router_pkg::ERR_UNMAPPED] = 1'b1;
      end
    end
    err_evt_nxt = |(err_nxt & ~err_r);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < irq_router_pkg::NUM_LOCAL; i++) begin
        entry_r[i] <= irq_router_pkg::ENTRY_RST;
      end
      periodic_r <= 1'b0;
      id_r <= irq_router_pkg::ID_RST;
      group_r <= irq_router_pkg::GROUP_RST;
      enable_r <= irq_router_pkg::ENABLE_RST;
      icr_lo_r <= 32'h00000000;
      icr_dest_r <= 8'h00;
      err_r <= '0;
      err_evt_r <= 1'b0;
      acc_ack_r <= 1'b0;
      acc_hit_r <= 1'b0;
      acc_rdata_r <= 32'h00000000;
    end else begin
      entry_r <= entry_nxt;
      periodic_r <= periodic_nxt;
      id_r <= id_nxt;
      group_r <= group_nxt;
      enable_r <= enable_nxt;
      icr_lo_r <= icr_lo_nxt;
      icr_dest_r <= icr_dest_nxt;
      err_r <= err_nxt;
      err_evt_r <= err_evt_nxt;
      acc_ack_r <= acc_ack_nxt;
      acc_hit_r <= acc_hit_nxt;
      acc_rdata_r <= acc_rdata_nxt;
    end
  end

  pin_sync #(.W(3)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({legacy_intr, local_irq_pin_b, local_irq_pin_a}),
    .pin_out(pins_sync)
  );

  irq_count_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_value(acc_req.wdata),
    .periodic(periodic_r),
    .count(tmr_count),
    .fire(tmr_fire)
  );

  // Messages: inbound slot, self slot, outbound bus message

  always_comb begin
    in_match = in_msg.broadcast || (in_msg.group ? |(in_msg.dest & group_r) : in_msg.dest == id_r);
    msg_set = in_msg_valid && in_ready_r && in_match && enable_r;
    in_slot_nxt = msg_set ? in_msg : in_slot_r;
    send_msg = '{dest: (send_sh == irq_router_pkg::SH_NONE) ? icr_dest_nxt : irq_router_pkg::BCAST_DEST,
                 group: acc_req.wdata[irq_router_pkg::DESTMODE_BIT],
                 broadcast: send_sh != irq_router_pkg::SH_NONE,
                 level: acc_req.wdata[irq_router_pkg::LEVEL_BIT],
                 mode: irq_router_pkg::dlv_mode_t'(acc_req.wdata[irq_router_pkg::MODE_LSB +: 2]),
                 vector: acc_req.wdata[irq_router_pkg::VEC_LSB +: 8]};
    self_set = icr_send && (send_sh == irq_router_pkg::SH_SELF || send_sh == irq_router_pkg::SH_ALL);
    self_slot_nxt = self_set ? send_msg : self_slot_r;
    bus_msg_valid_nxt = bus_msg_valid_r && !bus_msg_ready;
    bus_msg_nxt = bus_msg_r;
    if (icr_send && send_sh != irq_router_pkg::SH_SELF) begin
      bus_msg_valid_nxt = 1'b1;
      bus_msg_nxt = send_msg;
    end
    in_ready_nxt = !pend_nxt[irq_router_pkg::SRC_MSG];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_slot_r <= '0;
      self_slot_r <= '0;
      bus_msg_r <= '0;
      bus_msg_valid_r <= 1'b0;
      in_ready_r <= 1'b0;
    end else begin
      in_slot_r <= in_slot_nxt;
      self_slot_r <= self_slot_nxt;
      bus_msg_r <= bus_msg_nxt;
      bus_msg_valid_r <= bus_msg_valid_nxt;
      in_ready_r <= in_ready_nxt;
    end
  end

  // Pending flags and core delivery

  always_comb begin
    raw = {err_evt_r, thermal_trip, perf_overflow, tmr_fire, pins_sync[1], pins_sync[0]};
    prev_nxt = raw;
    for (int i = 0; i < irq_router_pkg::NUM_LOCAL; i++) begin
      set_loc[i] = enable_r && !entry_r[i].mask && (entry_r[i].level ? raw[i] : raw[i] && !prev_r[i]);
    end
    pend_nxt = pend_r;
    dlv_nxt = dlv_r;
    grant_nxt = grant_r;
    core_req_nxt = core_req_r;
    if (dlv_r == DS_OFFER && core_ack) begin
      pend_nxt[grant_r] = 1'b0;
      dlv_nxt = DS_IDLE;
    end
    pend_nxt[irq_router_pkg::NUM_LOCAL-1:0] = pend_nxt[irq_router_pkg::NUM_LOCAL-1:0] | set_loc;
    if (msg_set) begin
      pend_nxt[irq_router_pkg::SRC_MSG] = 1'b1;
    end
    if (self_set) begin
      pend_nxt[irq_router_pkg::SRC_SELF] = 1'b1;
    end
    pick = in_slot_r;
    if (dlv_r == DS_IDLE && |pend_r) begin
      for (int i = irq_router_pkg::NUM_SRC - 1; i >= 0; i--) begin
        if (pend_r[i]) begin
          grant_nxt = 3'(i);
        end
      end
      if (grant_nxt == 3'(irq_router_pkg::SRC_SELF)) begin
        pick = self_slot_r;
      end else if (grant_nxt != 3'(irq_router_pkg::SRC_MSG)) begin
        pick = '{dest: 8'h00, group: 1'b0, broadcast: 1'b0, level: entry_r[grant_nxt].level,
                 mode: entry_r[grant_nxt].mode, vector: entry_r[grant_nxt].vector};
      end
      core_req_nxt = '{vector: (pick.mode == irq_router_pkg::DLV_NMI) ? irq_router_pkg::NMI_VECTOR : pick.vector,
                       level: pick.level,
                       nmi: pick.mode == irq_router_pkg::DLV_NMI,
                       extint: pick.mode == irq_router_pkg::DLV_EXTINT};
      dlv_nxt = DS_OFFER;
    end
    core_valid_nxt = dlv_nxt == DS_OFFER;
    legacy_nxt = !enable_r && pins_sync[2];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
      prev_r <= '0;
      dlv_r <= DS_IDLE;
      grant_r <= 3'h0;
      core_valid_r <= 1'b0;
      core_req_r <= '0;
      legacy_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      prev_r <= prev_nxt;
      dlv_r <= dlv_nxt;
      grant_r <= grant_nxt;
      core_valid_r <= core_valid_nxt;
      core_req_r <= core_req_nxt;
      legacy_r <= legacy_nxt;
    end
  end

  assign acc_ack = acc_ack_r;
  assign acc_hit = acc_hit_r;
  assign acc_rdata = acc_rdata_r;
  assign core_irq_valid = core_valid_r;
  assign core_req = core_req_r;
  assign core_legacy_intr = legacy_r;
  assign in_msg_ready = in_ready_r;
  assign bus_msg_valid = bus_msg_valid_r;
  assign bus_msg = bus_msg_r;

endmodule // local_interrupt_source_router

// ### verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 3
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset
  input wire logic [W-1:0] pin_in, // Asynchronous pins
  output logic [W-1:0] pin_out // Synchronised levels
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pin_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign pin_out = sync_r;

endmodule // pin_sync
